/* File: rtl/pfb_pkg.sv */
// pfb_pkg: constants for the peripheral interrupt flag bank
// assumes a 32-bit classic wishbone bus with word-aligned registers
package pfb_pkg;

  // register bank geometry
  localparam int unsigned PFB_NUM_REGS = 5;
  localparam int unsigned PFB_REG_W = 8;
  localparam int unsigned PFB_FLAG_W = PFB_NUM_REGS * PFB_REG_W;
  localparam int unsigned PFB_ADR_W = 8;
  localparam int unsigned PFB_IDX_W = 6;

  // word indexes; byte address is four times the index
  localparam logic [5:0] PFB_IDX_FLAGS_ONE = 6'h00;
  localparam logic [5:0] PFB_IDX_FLAGS_FIVE = 6'h04;
  localparam logic [5:0] PFB_IDX_EN_ONE = 6'h05;
  localparam logic [5:0] PFB_IDX_EN_FIVE = 6'h09;
  localparam logic [5:0] PFB_IDX_CTRL = 6'h0a;
  localparam logic [5:0] PFB_IDX_PEND = 6'h0b;

  // control register fields
  localparam int unsigned PFB_CTRL_GATE_BIT = 0;
  localparam int unsigned PFB_CTRL_PRIO_BIT = 1;
  localparam logic [1:0] PFB_CTRL_RST = 2'h0;

  // reset value of every flag and enable register
  localparam logic [7:0] PFB_REG_RST = 8'h00;

  // implemented bits, register five down to register one
  localparam logic [39:0] PFB_IMPL_MASK = 40'h07_07_ff_ff_7f;
  // bits that follow a serial buffer level, writes have no effect
  localparam logic [39:0] PFB_RO_MASK = 40'h00_00_30_00_30;

  // flat positions of the level-driven serial flags
  localparam int unsigned PFB_SER1_RX_POS = 5;
  localparam int unsigned PFB_SER1_TX_POS = 4;
  localparam int unsigned PFB_SER2_RX_POS = 21;
  localparam int unsigned PFB_SER2_TX_POS = 20;

  // flat positions of capture/compare flags a..e
  localparam int unsigned PFB_CAPCMP_A_POS = 2;
  localparam int unsigned PFB_CAPCMP_B_POS = 8;
  localparam int unsigned PFB_CAPCMP_C_POS = 24;
  localparam int unsigned PFB_CAPCMP_D_POS = 25;
  localparam int unsigned PFB_CAPCMP_E_POS = 26;

  // other flat positions watched by checks
  localparam int unsigned PFB_CONV_DONE_POS = 6;
  localparam int unsigned PFB_SYNC1_DONE_POS = 3;
  localparam int unsigned PFB_OSC_FAIL_POS = 15;

endpackage : pfb_pkg

/* File: rtl/pfb_flag_bank.sv */
// pfb_flag_bank: five 8-bit peripheral interrupt request flag registers
// assumes all peripheral events and buffer levels come from logic on clk_i
// and that the register bus is a classic wishbone master on the same clock
// serial level inputs come straight from the buffer logic, no filtering
// the enable, control and pending words sit beside the flags for polling
//
// Notes on behaviour
// R01: conversion-done flag sets, software clears it
// R02: serial one receive flag mirrors buffer full
// R03: serial one transmit flag mirrors buffer empty
// R04: sync port one done flag sticky
// R05: capture/compare a,b set on event, not PWM
// R06: timer b period match flag sticky
// R07: timer a overflow flag sticky
// R08: oscillator fail flag sticky until cleared
// R09: comparator change flags sticky until cleared
// R10: nonvolatile write done flag sticky
// R11: sync port one collision flag sticky
// R12: voltage detect flag set on trip event
// R13: timer c overflow flag sticky
// R14: sync port two done, collision flags sticky
// R15: serial two flags mirror buffer levels
// R16: charge time unit flag sticky
// R17: timer gate flags cleared only by software
// R18: capture/compare c,d,e set, not PWM
// R19: register five timer flags sticky
// R20: unimplemented bits read as zero
// R21: all flags zero after reset
// R22: no request without gate when priority off
// R23: flags set regardless of enable bits
// R24: hardware set beats software clear
// R25: writes to serial level flags ignored
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/10ps

module pfb_flag_bank
  import pfb_pkg::*;
#(
  parameter int unsigned NUM_REGS = PFB_NUM_REGS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [PFB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // one-cycle event pulses, bit 8*r+b sets flag b of register r
  input wire logic [PFB_FLAG_W-1:0] evt_i,
  // capture/compare units a..e in pwm mode
  input wire logic [4:0] capcmp_pwm_i,
  // serial buffer levels
  input wire logic ser1_rx_full_i,
  input wire logic ser1_tx_empty_i,
  input wire logic ser2_rx_full_i,
  input wire logic ser2_tx_empty_i,
  // flag image and interrupt request
  output logic [PFB_FLAG_W-1:0] flags_o,
  output logic periph_irq_o
);

  // the bank layout is fixed by the masks in the package
  if (NUM_REGS != PFB_NUM_REGS) begin : g_bad_regs
    $error("pfb_flag_bank: NUM_REGS must equal PFB_NUM_REGS");
  end

  // bus decode
  // a request is taken only while no answer is pending, so a strobe
  // held through its own ack is not taken twice
  // byte lanes other than lane zero are ignored, registers are 8 bits
  logic bus_req; // valid request, not yet answered
  logic bus_wr; // write taken this cycle
  logic [PFB_IDX_W-1:0] bus_idx; // word index of the access
  logic ack_q; // answer pulse
  logic [31:0] dat_q; // read data held for the answer
  logic [31:0] rd_mux; // read data selected by index

  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  assign bus_idx = wb_adr_i[PFB_ADR_W-1:2];

  // control and enable state
  // in priority mode the gate is left to the priority logic downstream
  logic [1:0] ctrl_q; // gate and priority mode
  logic [1:0] ctrl_d;
  logic ctrl_wr;
  logic periph_irq_gate; // peripheral gate enable
  logic priority_mode_on; // priority levels in use

  assign ctrl_wr = bus_wr & (bus_idx == PFB_IDX_CTRL);
  assign ctrl_d = ctrl_wr ? wb_dat_i[1:0] : ctrl_q;
  assign periph_irq_gate = ctrl_q[PFB_CTRL_GATE_BIT];
  assign priority_mode_on = ctrl_q[PFB_CTRL_PRIO_BIT];

  // flat views of the bank
  // bit 8*r+b of every vector is flag b of register r, as on evt_i
  logic [PFB_FLAG_W-1:0] flag_q; // all flags
  logic [PFB_FLAG_W-1:0] flag_d;
  logic [PFB_FLAG_W-1:0] en_q; // all enables
  logic [PFB_FLAG_W-1:0] en_d;
  logic [PFB_FLAG_W-1:0] lvl_vec; // serial buffer levels in place
  logic [PFB_FLAG_W-1:0] pwm_vec; // capture/compare in pwm mode
  logic [PFB_FLAG_W-1:0] evt_ok; // events that may set a flag
  logic [PFB_FLAG_W-1:0] pend_vec; // flags that are enabled
  logic [7:0] pend_reg; // any pending per register

  // level flags track the serial ports only  [R02] [R03] [R15]
  // buffer access clearing lives in the serial ports; here the flag
  // is only a registered copy of the level, one cycle behind
  always_comb begin
    lvl_vec = '0;
    lvl_vec[PFB_SER1_RX_POS] = ser1_rx_full_i;
    lvl_vec[PFB_SER1_TX_POS] = ser1_tx_empty_i;
    lvl_vec[PFB_SER2_RX_POS] = ser2_rx_full_i;
    lvl_vec[PFB_SER2_TX_POS] = ser2_tx_empty_i;
  end

  // a unit in pwm mode never raises its flag  [R05] [R18]
  // a pwm unit may still pulse its event line, so the mask is needed
  always_comb begin
    pwm_vec = '0;
    pwm_vec[PFB_CAPCMP_A_POS] = capcmp_pwm_i[0];
    pwm_vec[PFB_CAPCMP_B_POS] = capcmp_pwm_i[1];
    pwm_vec[PFB_CAPCMP_C_POS] = capcmp_pwm_i[2];
    pwm_vec[PFB_CAPCMP_D_POS] = capcmp_pwm_i[3];
    pwm_vec[PFB_CAPCMP_E_POS] = capcmp_pwm_i[4];
  end

  // events set flags whatever the enables say  [R23]
  // level and unimplemented bits are masked so no event reaches them
  assign evt_ok = evt_i & ~pwm_vec & PFB_IMPL_MASK & ~PFB_RO_MASK;
  assign pend_vec = flag_q & en_q;

  // per register next values
  // a write of one to a sticky flag sets it, which lets software test
  // the request path without a live peripheral
  for (genvar r = 0; r < PFB_NUM_REGS; r++) begin : g_reg
    logic flag_wr; // software write to this flag register
    logic en_wr; // software write to this enable register
    logic [7:0] impl; // implemented bits
    logic [7:0] ro; // level-driven bits
    logic [7:0] keep; // value surviving the write

    assign flag_wr = bus_wr & (bus_idx == PFB_IDX_W'(r));
    assign en_wr = bus_wr &
      (bus_idx == PFB_IDX_W'(r) + PFB_IDX_EN_ONE);
    assign impl = PFB_IMPL_MASK[8*r +: 8];
    assign ro = PFB_RO_MASK[8*r +: 8];
    // software write ignores level bits  [R25]
    assign keep = flag_wr ? wb_dat_i[7:0] : flag_q[8*r +: 8];
    // set after clear, so a same-cycle event survives  [R24]
    // sticky flags hold until written to zero  [R01] [R04] [R06] [R07]
    // [R08] [R09] [R10] [R11] [R12] [R13] [R14] [R16] [R17] [R19]
    assign flag_d[8*r +: 8] = (((keep | evt_ok[8*r +: 8]) & ~ro) |
      (lvl_vec[8*r +: 8] & ro)) & impl; // [R20]
    assign en_d[8*r +: 8] =
      (en_wr ? wb_dat_i[7:0] : en_q[8*r +: 8]) & impl;
    assign pend_reg[r] = |pend_vec[8*r +: 8];
  end
  assign pend_reg[7:PFB_NUM_REGS] = '0;

  // request gating: without priority levels the gate must be on  [R22]
  // the request only says that something is pending, not what
  logic irq_d;
  assign irq_d = (|pend_vec) & (priority_mode_on | periph_irq_gate);

  // read mux, unmapped words read zero  [R20]
  // the pending word is a summary only; writes to it are dropped
  // flag_sel may point past the bank when idx_flag is low; unused then
  logic idx_flag;
  logic idx_en;
  logic [2:0] flag_sel;
  logic [2:0] en_sel;
  assign idx_flag = bus_idx <= PFB_IDX_FLAGS_FIVE;
  assign idx_en = (bus_idx >= PFB_IDX_EN_ONE) &
    (bus_idx <= PFB_IDX_EN_FIVE);
  assign flag_sel = bus_idx[2:0];
  assign en_sel = 3'(bus_idx - PFB_IDX_EN_ONE);
  assign rd_mux =
    idx_flag ? {24'h0, flag_q[8*flag_sel +: 8]} :
    idx_en ? {24'h0, en_q[8*en_sel +: 8]} :
    (bus_idx == PFB_IDX_CTRL) ? {30'h0, ctrl_q} :
    (bus_idx == PFB_IDX_PEND) ? {24'h0, pend_reg} : 32'h0;

  // flag and enable state, all zero at reset  [R21]
  // enables and control share the reset so no stale request survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= {PFB_NUM_REGS{PFB_REG_RST}};
      en_q <= {PFB_NUM_REGS{PFB_REG_RST}};
      ctrl_q <= PFB_CTRL_RST;
    end else begin
      flag_q <= flag_d;
      en_q <= en_d;
      ctrl_q <= ctrl_d;
    end
  end

  // bus answer: one wait state, ack for exactly one cycle
  // read data is zero outside the answer cycle, which keeps the bus
  // mux downstream simple at the cost of a 32-bit register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= bus_req;
      // reads show state as of the accepting edge
      dat_q <= bus_req ? rd_mux : 32'h0;
    end
  end

  // interrupt request and flag image, both from flops
  // a registered request trades one cycle of latency for a clean output
  logic irq_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d; // one cycle behind the flags, by design
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign flags_o = flag_q;
  assign periph_irq_o = irq_q;

  // checks
  // all checks run on the one clock and are off while reset is high,
  // except the reset check itself, which overrides the default
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [7:0] wr_flag_one; // write strobe to flag register one
  logic [7:0] wr_flag_two;
  assign wr_flag_one = {8{bus_wr & (bus_idx == 6'h00)}};
  assign wr_flag_two = {8{bus_wr & (bus_idx == 6'h01)}};

  // write strobes of the other flag registers, for the hold checks
  logic wr_flag_three;
  logic wr_flag_four;
  logic wr_flag_five;
  logic [PFB_FLAG_W-1:0] sticky_mask; // flags only software may clear
  assign wr_flag_three = bus_wr & (bus_idx == 6'h02);
  assign wr_flag_four = bus_wr & (bus_idx == 6'h03);
  assign wr_flag_five = bus_wr & (bus_idx == 6'h04);
  assign sticky_mask = PFB_IMPL_MASK & ~PFB_RO_MASK;

  chk_conv_done_set: assert property ( // [R01]
    evt_i[PFB_CONV_DONE_POS] |=> flag_q[PFB_CONV_DONE_POS]
  ) else $error("conversion done event lost");

  chk_ser1_rx_level: assert property ( // [R02]
    ##1 flag_q[PFB_SER1_RX_POS] == $past(ser1_rx_full_i)
  ) else $error("serial one receive flag not following buffer");

  chk_ser1_tx_level: assert property ( // [R03]
    ##1 flag_q[PFB_SER1_TX_POS] == $past(ser1_tx_empty_i)
  ) else $error("serial one transmit flag not following buffer");

  chk_sticky_hold: assert property ( // [R04]
    flag_q[PFB_SYNC1_DONE_POS] && !wr_flag_one[0]
      |=> flag_q[PFB_SYNC1_DONE_POS]
  ) else $error("sync port flag dropped without a write");

  chk_pwm_ignored: assert property ( // [R05]
    capcmp_pwm_i[0] && !flag_q[PFB_CAPCMP_A_POS] && !wr_flag_one[0]
      |=> !flag_q[PFB_CAPCMP_A_POS]
  ) else $error("capture flag set in pwm mode");

  chk_unimpl_zero: assert property ( // [R20]
    flag_q[39:35] == 5'h0 && flag_q[31:27] == 5'h0 && !flag_q[7] &&
    (wb_ack_o && wb_dat_o[31:8] != 24'h0) == 1'b0
  ) else $error("unimplemented bit reads nonzero");

  chk_gate_blocks: assert property ( // [R22]
    !priority_mode_on && !periph_irq_gate |=> !periph_irq_o
  ) else $error("request raised with peripheral gate off");

  chk_irq_raise: assert property ( // [R22]
    periph_irq_gate && (|pend_vec) |=> periph_irq_o
  ) else $error("enabled pending flag raised no request");

  chk_set_wins: assert property ( // [R24]
    wr_flag_two[0] && wb_dat_i[7] == 1'b0 && evt_i[PFB_OSC_FAIL_POS]
      |=> flag_q[PFB_OSC_FAIL_POS]
  ) else $error("same-cycle event lost to software clear");

  chk_ro_ignored: assert property ( // [R25]
    wr_flag_one[0] && wb_dat_i[5] && !ser1_rx_full_i
      |=> !flag_q[PFB_SER1_RX_POS]
  ) else $error("write reached a level-driven flag");

  chk_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o
  ) else $error("ack held longer than one cycle");

  // a sticky flag drops only through a write to its own register
  chk_one_hold: assert property ( // [R01] [R06] [R07]
    !wr_flag_one[0] |=>
      ($past(flag_q[7:0]) & ~flag_q[7:0] & sticky_mask[7:0]) == 8'h0
  ) else $error("register one flag dropped without a write");

  chk_two_hold: assert property ( // [R08] [R09] [R10] [R11] [R12] [R13]
    !wr_flag_two[0] |=>
      ($past(flag_q[15:8]) & ~flag_q[15:8] & sticky_mask[15:8]) == 8'h0
  ) else $error("register two flag dropped without a write");

  chk_three_hold: assert property ( // [R14] [R16] [R17]
    !wr_flag_three |=>
      ($past(flag_q[23:16]) & ~flag_q[23:16] & sticky_mask[23:16]) == 8'h0
  ) else $error("register three flag dropped without a write");

  chk_four_hold: assert property ( // [R18]
    !wr_flag_four |=>
      ($past(flag_q[31:24]) & ~flag_q[31:24] & sticky_mask[31:24]) == 8'h0
  ) else $error("register four flag dropped without a write");

  chk_five_hold: assert property ( // [R19]
    !wr_flag_five |=>
      ($past(flag_q[39:32]) & ~flag_q[39:32] & sticky_mask[39:32]) == 8'h0
  ) else $error("register five flag dropped without a write");

  // both serial two flags are the buffer levels one cycle late
  chk_ser2_rx_level: assert property ( // [R15]
    ##1 flag_q[PFB_SER2_RX_POS] == $past(ser2_rx_full_i)
  ) else $error("serial two receive flag not following buffer");

  chk_ser2_tx_level: assert property ( // [R15]
    ##1 flag_q[PFB_SER2_TX_POS] == $past(ser2_tx_empty_i)
  ) else $error("serial two transmit flag not following buffer");

  // writes of one to the port two transmit flag are dropped
  chk_ro_ignored_two: assert property ( // [R25]
    wr_flag_three && wb_dat_i[4] && !ser2_tx_empty_i
      |=> !flag_q[PFB_SER2_TX_POS]
  ) else $error("write reached a level-driven flag of port two");

  // every accepted event is visible one cycle later
  chk_evt_sets: assert property ( // [R23]
    (|evt_ok) |=> (flag_q & $past(evt_ok)) == $past(evt_ok)
  ) else $error("event did not set its flag");

  // the answer comes exactly one cycle after the request is taken
  chk_ack_after_req: assert property (
    bus_req |=> wb_ack_o
  ) else $error("request taken but not answered");

  // read data stays zero outside the answer cycle
  chk_idle_data_zero: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0
  ) else $error("read data shown outside the answer cycle");

  // the reset check is the one check that must run during reset
  chk_reset_clear: assert property ( // [R21]
    @(posedge clk_i) disable iff (1'b0)
    rst_i |=> flag_q == '0 && en_q == '0 && !periph_irq_o && !wb_ack_o
  ) else $error("state not cleared by reset");

  cov_flag_irq: cover property (
    evt_i[PFB_CONV_DONE_POS] ##1 1'b1 ##1 periph_irq_o
  );
  cov_set_clear: cover property (
    wr_flag_two[0] && evt_i[PFB_OSC_FAIL_POS]
  );
  cov_rx_cycle: cover property (
    $rose(flag_q[PFB_SER1_RX_POS]) ##[1:20] $fell(flag_q[PFB_SER1_RX_POS])
  );
  cov_prio_irq: cover property (
    priority_mode_on && !periph_irq_gate && periph_irq_o
  );
  cov_level_write: cover property (
    wr_flag_one[0] && wb_dat_i[5] && !ser1_rx_full_i
  );

endmodule : pfb_flag_bank

/* File: tb/pfb_periph_model.sv */
// pfb_periph_model: stands in for the peripherals around the flag bank
// assumes one clock shared with the bank; events are one-cycle pulses
`timescale 1ns/10ps

module pfb_periph_model
  import pfb_pkg::*;
(
  input wire logic clk_i,
  output logic [PFB_FLAG_W-1:0] evt_o,
  output logic [4:0] pwm_o,
  output logic [3:0] lvl_o
);
  // idle: no events, no pwm, all buffer levels low
  initial begin
    evt_o = '0;
    pwm_o = 5'h00;
    lvl_o = 4'h0;
  end

  // one-cycle set pulse, launched right after an edge
  task automatic pulse(input logic [PFB_FLAG_W-1:0] m);
    @(posedge clk_i);
    evt_o <= m;
    @(posedge clk_i);
    evt_o <= '0;
  endtask : pulse

  // lvl order: ser1 rx full, ser1 tx empty, ser2 rx full, ser2 tx empty
  task automatic set_mode(input logic [4:0] p, input logic [3:0] l);
    @(posedge clk_i);
    pwm_o <= p;
    lvl_o <= l;
  endtask : set_mode
endmodule : pfb_periph_model

/* File: tb/pfb_flag_bank_test.sv */
// pfb_flag_bank_test: register-level tests of the flag bank
// assumes the bank answers one wait state after a classic wishbone request
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("mismatch %s exp %h got %h", n, e, g); \
  end \
end

module pfb_flag_bank_test;
  import pfb_pkg::*;
  // flags that software can write, level flags excluded
  localparam logic [39:0] SW_MASK = PFB_IMPL_MASK & ~PFB_RO_MASK;
  logic clk_i, rst_i, cyc, stb, we, ack, irq;
  logic [7:0] adr, rd;
  logic [3:0] sel;
  logic [31:0] dat, dat_o;
  logic [39:0] evt, flags;
  logic [4:0] pwm;
  logic [3:0] lvl;
  logic [5:0] ix;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;

  pfb_flag_bank dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .evt_i(evt),
    .capcmp_pwm_i(pwm), .ser1_rx_full_i(lvl[3]), .ser1_tx_empty_i(lvl[2]),
    .ser2_rx_full_i(lvl[1]), .ser2_tx_empty_i(lvl[0]), .flags_o(flags),
    .periph_irq_o(irq));

  pfb_periph_model model (.clk_i(clk_i), .evt_o(evt), .pwm_o(pwm),
    .lvl_o(lvl));

  // 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // classic cycle: hold until ack is seen at an edge, then release
  task automatic wb(input logic w, input logic [5:0] i,
                    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'h0};
    dat <= {24'h0, d};
    sel <= 4'h1;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic rd_chk(input string n, input logic [5:0] i,
                        input logic [7:0] e);
    wb(1'b0, i, 8'h00, rd);
    `CHK(n, e, rd)
  endtask : rd_chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  initial begin
    rst_i = 1'b1;
    {cyc, stb, we} = 3'h0;
    adr = 8'h00;
    dat = 32'h0;
    sel = 4'h1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    // every register after reset, index 12 is unmapped
    for (int i = 0; i < 13; i++) rd_chk("reset", 6'(i), 8'h00);
    // per register: set all events, raise the request by gate or priority mode, clear
    for (int r = 0; r < 5; r++) begin
      ix = 6'(r);
      wb(1'b1, PFB_IDX_EN_ONE + ix, 8'hff, rd);
      rd_chk("enable", PFB_IDX_EN_ONE + ix, PFB_IMPL_MASK[8*r +: 8]);
      model.pulse(40'hff << (8 * r));
      rd_chk("flags", ix, SW_MASK[8*r +: 8]);
      `CHK("image", SW_MASK[8*r +: 8], flags[8*r +: 8])
      `CHK("irq off", 1'b0, irq)
      wb(1'b1, PFB_IDX_CTRL, r[0] ? 8'h02 : 8'h01, rd);
      repeat (2) @(posedge clk_i);
      `CHK("irq on", 1'b1, irq)
      rd_chk("pending", PFB_IDX_PEND, 8'h01 << r);
      wb(1'b1, PFB_IDX_CTRL, 8'h00, rd);
      wb(1'b1, ix, 8'h00, rd);
      rd_chk("cleared", ix, 8'h00);
    end
    // level flags follow the buffers, writes of one have no effect
    model.set_mode(5'h00, 4'ha);
    wb(1'b1, 6'h02, 8'h30, rd);
    rd_chk("ser1 rx", 6'h00, 8'h20);
    rd_chk("ser2 rx", 6'h02, 8'h20);
    model.set_mode(5'h00, 4'h5);
    wb(1'b1, 6'h00, 8'h30, rd);
    rd_chk("ser1 tx", 6'h00, 8'h10);
    rd_chk("ser2 tx", 6'h02, 8'h10);
    // capture/compare events are dropped in pwm mode only
    model.set_mode(5'h1f, 4'h0);
    model.pulse(40'h00_07_00_01_04);
    rd_chk("pwm a", 6'h00, 8'h00);
    rd_chk("pwm b", 6'h01, 8'h00);
    rd_chk("pwm cde", 6'h03, 8'h00);
    model.set_mode(5'h00, 4'h0);
    model.pulse(40'h00_07_00_01_04);
    rd_chk("capcmp a", 6'h00, 8'h04);
    rd_chk("capcmp b", 6'h01, 8'h01);
    rd_chk("capcmp cde", 6'h03, 8'h07);
    // clear of register one lands on the edge of a new event
    fork
      wb(1'b1, 6'h00, 8'h00, rd);
      model.pulse(40'h1);
    join
    rd_chk("set wins", 6'h00, 8'h01);
    // the same race on register two, oscillator fail against a clear
    fork
      wb(1'b1, 6'h01, 8'h00, rd);
      model.pulse(40'h80_00);
    join
    rd_chk("set wins two", 6'h01, 8'h80);
    // a second reset in mid-run clears every flag again
    model.pulse(40'h07_07_ff_ff_7f);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK("image reset", 40'h0, flags)
    for (int i = 0; i < 12; i++) rd_chk("rerun", 6'(i), 8'h00);
    report_and_stop();
  end
endmodule : pfb_flag_bank_test
